/* hdl/ssp_ctrl.sv */
`timescale 1ns/1ps
`include "ssp_defs.svh"
// Behaviour
// R1: Writing the transmit buffer clears the transmit-empty flag.
// R2: Internal clock, transmit: clock held high until new data is written.
// R3: Data written during a byte is sent right after it, no gap.
// R4: External clock: software refills transmit buffer before the next byte starts.
// R5: Byte start with empty buffer sets underrun, interrupt at next falling edge.
// R6: First byte started before any write also sets underrun and interrupts.
// R7: Underrun holds data-out high; software recovers with force stop.
// R8: Clearing start finishes the current byte, then stops with data-out high.
// R9: External clock: software clears start before the next byte begins.
// R10: Force stop halts at once and clears start, status and both buffers.
// R11: Mode code 01 selects receive only.
// R12: Receive samples data-in on rising edges in the selected bit order.
// R13: Shift-active flag is high from first to eighth falling edge; the code clears it at the eighth rising edge.
// R14: A full received byte goes to receive buffer, sets full flag, interrupts.
// R15: Internal clock receive starts the clock within one serial cycle.
// R16: Reading the receive buffer clears the receive-full flag.
// R17: Internal clock, receive: clock held high until receive buffer is read.
// R18: External clock: software reads receive buffer before next byte completes.
// R19: Byte completing with receive buffer unread sets overrun and interrupts.
// R20: During overrun bits are ignored; reads give old byte, then shift register.
// R21: No interrupt while an overrun stays uncleared.
// R22: Mode code 10 selects full duplex, out on falling, in on rising.
// R23: Mode code 00 selects transmit only.
// R24: Clock select 111 takes the clock from the pin; others divide internally.
// R25: Bit order 0 sends bit 7 first, 1 sends bit 0 first.
// R26: Full duplex: empty flag set at rising edge after load; irq with full flag.
module ssp_ctrl (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Control
    input wire logic start_set,
    input wire logic start_clr,
    input wire logic force_stop,
    input wire ssp_pkg::ssp_mode_t transfer_mode_field,
    input wire logic [2:0] clock_select_field,
    input wire logic bit_order_bit,
    // Transmit buffer write
    input wire logic tx_wr,
    input wire logic [7:0] tx_wdata,
    // Receive buffer read stream
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    // Status
    output logic transfer_start_bit,
    output logic tx_buffer_empty_flag,
    output logic rx_buffer_full_flag,
    output logic transfer_active_flag,
    output logic shift_active_flag,
    output logic tx_underrun_flag,
    output logic rx_overrun_flag,
    output logic serial_done_irq,
    // Serial pins
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic serial_in_pin,
    output logic serial_out_pin
);
    import ssp_pkg::*;

    ssp_state_t state_q, state_d;
    logic start_q, start_d, active_q, active_d, sef_q, sef_d;
    logic txf_q, txf_d, rxf_q, rxf_d, tx_underrun_flag_q, tx_underrun_flag_d, rx_overrun_flag_q, rx_overrun_flag_d;
    logic rd_once_q, rd_once_d, pend_q, pend_d, irq_q, irq_d;
    logic tdb_full_q, tdb_full_d, run_q, run_d;
    logic sck_q, sck_d, sck_prev_q, so_q, so_d, oe_q, oe_d;
    logic [7:0] tdb_q, tdb_d, rdb_q, rdb_d, sh_q, sh_d;
    logic [3:0] bitcnt_q, bitcnt_d;
    logic ext, tick, fall_e, rise_e, rd_hs, rx_end_e, buf_in_ready, ready_ok;
    logic [7:0] buf_in_data;

    function automatic logic tx_path(input ssp_mode_t m);
        return (m == SSP_MODE_TX) || (m == SSP_MODE_TRX);
    endfunction : tx_path

    function automatic logic rx_path(input ssp_mode_t m);
        return (m == SSP_MODE_RX) || (m == SSP_MODE_TRX);
    endfunction : rx_path

    function automatic logic out_bit(input logic [7:0] v, input logic lsb_first);
        return lsb_first ? v[0] : v[7];
    endfunction : out_bit

    ssp_presc u_presc (
        .core_clk(core_clk),
        .rst(rst),
        .run(run_q),
        .sel(clock_select_field),
        .tick(tick)
    );

    // Reading the receive buffer is the buffer accepting the word
    ssp_buf2 #(.W(8)) u_rxbuf (
        .core_clk(core_clk),
        .rst(rst),
        .in_valid(rxf_q),
        .in_ready(buf_in_ready),
        .in_data(buf_in_data),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_data)
    );

    assign ext = (clock_select_field == `SSP_SEL_EXT); // [R24]
    assign fall_e = ext ? (sck_prev_q && !sck_in) : (run_q && tick && sck_q);
    assign rise_e = ext ? (!sck_prev_q && sck_in) : (run_q && tick && !sck_q);
    assign rd_hs = rxf_q && buf_in_ready;
    assign rx_end_e = rise_e && (state_q == SSP_ST_SHIFT) && (bitcnt_q == `SSP_BITS) && rx_path(transfer_mode_field);
    // Second read during overrun returns the held shift register
    assign buf_in_data = (rx_overrun_flag_q && rd_once_q) ? sh_q : rdb_q; // [R20]

    always_comb begin
        state_d = state_q;
        start_d = start_q;
        sef_d = sef_q;
        txf_d = txf_q;
        rxf_d = rxf_q;
        tx_underrun_flag_d = tx_underrun_flag_q;
        rx_overrun_flag_d = rx_overrun_flag_q;
        rd_once_d = rd_once_q;
        pend_d = pend_q;
        irq_d = 1'b0;
        tdb_full_d = tdb_full_q;
        tdb_d = tdb_q;
        rdb_d = rdb_q;
        sh_d = sh_q;
        bitcnt_d = bitcnt_q;
        so_d = so_q;
        if (start_set) begin
            start_d = 1'b1;
        end
        if (start_clr) begin
            start_d = 1'b0;
        end
        if (tx_wr) begin
            tdb_d = tx_wdata;
            tdb_full_d = 1'b1;
            txf_d = 1'b0; // [R1]
        end
        if (rd_hs) begin
            if (rx_overrun_flag_q && !rd_once_q) begin
                rd_once_d = 1'b1; // [R20]
            end else begin
                rxf_d = 1'b0; // [R16]
                rx_overrun_flag_d = 1'b0;
                rd_once_d = 1'b0;
            end
        end
        unique case (state_q)
            SSP_ST_IDLE, SSP_ST_GAP: begin
                if (!start_q) begin
                    state_d = SSP_ST_IDLE; // [R8] [R9]
                end else if (fall_e) begin
                    state_d = SSP_ST_SHIFT;
                    sef_d = 1'b1; // [R13]
                    bitcnt_d = 4'h1;
                    so_d = `SSP_LINE_IDLE;
                    if (tx_path(transfer_mode_field)) begin // [R22] [R23]
                        if (tdb_full_q) begin
                            sh_d = tdb_q; // [R3]
                            tdb_full_d = tx_wr;
                            so_d = out_bit(tdb_q, bit_order_bit); // [R25]
                        end else begin
                            tx_underrun_flag_d = 1'b1; // [R5] [R6]
                        end
                        pend_d = (transfer_mode_field == SSP_MODE_TX);
                    end
                end
            end
            SSP_ST_SHIFT: begin
                if (fall_e && bitcnt_q != `SSP_BITS) begin
                    bitcnt_d = bitcnt_q + 4'h1;
                    so_d = tx_path(transfer_mode_field) ? out_bit(sh_q, bit_order_bit) : `SSP_LINE_IDLE;
                    if (pend_q) begin
                        irq_d = 1'b1; // [R5]
                        pend_d = 1'b0;
                    end
                end
                if (rise_e) begin
                    if (!(rx_path(transfer_mode_field) && rx_overrun_flag_q)) begin
                        // Transmit also shifts here so the next bit reaches the output end
                        sh_d = bit_order_bit ? {serial_in_pin, sh_q[7:1]} : {sh_q[6:0], serial_in_pin}; // [R12]
                    end
                    if (bitcnt_q == 4'h1 && tx_path(transfer_mode_field)) begin
                        txf_d = !tdb_full_d; // [R26]
                    end
                    if (bitcnt_q == `SSP_BITS) begin
                        sef_d = 1'b0; // [R13]
                        state_d = start_q ? SSP_ST_GAP : SSP_ST_IDLE; // [R8]
                        if (!start_q) begin
                            so_d = `SSP_LINE_IDLE;
                        end
                        if (rx_path(transfer_mode_field) && !rx_overrun_flag_q) begin // [R11]
                            if (rxf_q && !rd_hs) begin
                                rx_overrun_flag_d = 1'b1; // [R19]
                                irq_d = 1'b1;
                            end else begin
                                rdb_d = sh_d; // [R14]
                                rxf_d = 1'b1;
                                irq_d = 1'b1; // [R26]
                            end
                        end
                    end
                end
            end
        endcase
        if (tx_underrun_flag_d || !tx_path(transfer_mode_field)) begin
            so_d = `SSP_LINE_IDLE; // [R7]
        end
        // Internal clock pauses between bytes until the buffers the selected mode uses are serviced
        ready_ok = (!tx_path(transfer_mode_field) || tdb_full_d) && (!rx_path(transfer_mode_field) || !rxf_d);
        run_d = !ext && ((state_d == SSP_ST_SHIFT) || (start_d && ready_ok)); // [R2] [R15] [R17]
        sck_d = ext ? 1'b1 : ((run_q && tick) ? !sck_q : sck_q);
        if (state_d != SSP_ST_SHIFT && !run_d) begin
            sck_d = 1'b1; // [R2] [R17]
        end
        oe_d = !ext;
        if (force_stop) begin // [R10]
            state_d = SSP_ST_IDLE;
            start_d = 1'b0;
            sef_d = 1'b0;
            txf_d = `SSP_TXF_RST;
            rxf_d = 1'b0;
            tx_underrun_flag_d = 1'b0;
            rx_overrun_flag_d = 1'b0;
            rd_once_d = 1'b0;
            pend_d = 1'b0;
            irq_d = 1'b0;
            tdb_full_d = 1'b0;
            tdb_d = `SSP_DATA_RST;
            rdb_d = `SSP_DATA_RST;
            sh_d = `SSP_DATA_RST;
            bitcnt_d = 4'h0;
            so_d = `SSP_LINE_IDLE;
            run_d = 1'b0;
            sck_d = 1'b1;
        end
        if (rx_overrun_flag_q) begin
            irq_d = 1'b0; // [R21]
        end
        active_d = (state_d != SSP_ST_IDLE);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= SSP_ST_IDLE;
            start_q <= 1'b0;
            active_q <= 1'b0;
            sef_q <= 1'b0;
            txf_q <= `SSP_TXF_RST;
            rxf_q <= 1'b0;
            tx_underrun_flag_q <= 1'b0;
            rx_overrun_flag_q <= 1'b0;
            rd_once_q <= 1'b0;
            pend_q <= 1'b0;
            irq_q <= 1'b0;
            tdb_full_q <= 1'b0;
            tdb_q <= `SSP_DATA_RST;
            rdb_q <= `SSP_DATA_RST;
            sh_q <= `SSP_DATA_RST;
            bitcnt_q <= 4'h0;
            run_q <= 1'b0;
            sck_q <= 1'b1;
            sck_prev_q <= 1'b1;
            so_q <= `SSP_LINE_IDLE;
            oe_q <= 1'b0;
        end else begin
            state_q <= state_d;
            start_q <= start_d;
            active_q <= active_d;
            sef_q <= sef_d;
            txf_q <= txf_d;
            rxf_q <= rxf_d;
            tx_underrun_flag_q <= tx_underrun_flag_d;
            rx_overrun_flag_q <= rx_overrun_flag_d;
            rd_once_q <= rd_once_d;
            pend_q <= pend_d;
            irq_q <= irq_d;
            tdb_full_q <= tdb_full_d;
            tdb_q <= tdb_d;
            rdb_q <= rdb_d;
            sh_q <= sh_d;
            bitcnt_q <= bitcnt_d;
            run_q <= run_d;
            sck_q <= sck_d;
            sck_prev_q <= sck_in;
            so_q <= so_d;
            oe_q <= oe_d;
        end
    end

    assign transfer_start_bit = start_q;
    assign tx_buffer_empty_flag = txf_q;
    assign rx_buffer_full_flag = rxf_q;
    assign transfer_active_flag = active_q;
    assign shift_active_flag = sef_q;
    assign tx_underrun_flag = tx_underrun_flag_q;
    assign rx_overrun_flag = rx_overrun_flag_q;
    assign serial_done_irq = irq_q;
    assign sck_out = sck_q;
    assign sck_oe = oe_q;
    assign serial_out_pin = so_q;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    sequence byte_start_s;
        fall_e && start_q && (state_q != SSP_ST_SHIFT) && !force_stop;
    endsequence

    sequence underrun_s;
        byte_start_s ##0 (tx_path(transfer_mode_field) && !tdb_full_q);
    endsequence

    tx_write_clear_a: assert property (tx_wr && !force_stop |=> !tx_buffer_empty_flag) // [R1]
        else $error("write did not clear empty flag");
    sef_start_a: assert property (byte_start_s |=> shift_active_flag && transfer_active_flag) // [R13]
        else $error("shift flag not raised at byte start");
    underrun_set_a: assert property (underrun_s |=> tx_underrun_flag && serial_out_pin) // [R5] [R6]
        else $error("underrun not flagged at byte start");
    underrun_line_a: assert property (tx_underrun_flag |-> serial_out_pin) // [R7]
        else $error("data out not high during underrun");
    force_stop_a: assert property (force_stop |=> !transfer_start_bit && !transfer_active_flag
        && !rx_buffer_full_flag && !tx_underrun_flag && !rx_overrun_flag && tx_buffer_empty_flag) // [R10]
        else $error("force stop did not clear state");
    rx_read_clear_a: assert property (rd_hs && !rx_overrun_flag_q && !rx_end_e && !force_stop |=> !rx_buffer_full_flag) // [R16]
        else $error("read did not clear full flag");
    rx_capture_a: assert property (rx_end_e && !rx_overrun_flag_q && !(rxf_q && !rd_hs) && !force_stop
        |=> rx_buffer_full_flag && serial_done_irq && !rx_overrun_flag) // [R14]
        else $error("received byte not captured");
    overrun_set_a: assert property (rx_end_e && !rx_overrun_flag_q && rxf_q && !rd_hs && !force_stop
        |=> rx_overrun_flag && serial_done_irq) // [R19]
        else $error("overrun not flagged");
    err_quiet_a: assert property (rx_overrun_flag |=> !serial_done_irq) // [R21]
        else $error("interrupt raised during overrun");
    clock_hold_a: assert property (!ext && state_q != SSP_ST_SHIFT && !run_q |-> sck_out) // [R2] [R17]
        else $error("serial clock not held high while waiting");
    rx_sample_a: assert property (rise_e && state_q == SSP_ST_SHIFT && rx_path(transfer_mode_field)
        && !rx_overrun_flag_q && !bit_order_bit && !force_stop |=> sh_q[0] == $past(serial_in_pin)) // [R12] [R25]
        else $error("data in not sampled on rising edge");

endmodule : ssp_ctrl

/* common/ssp_defs.svh */
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH

// Clock select code for the external serial clock
`define SSP_SEL_EXT 3'h7

// Divider exponents: serial clock is core_clk / 2^n
`define SSP_EXP_SEL0 4'hc
`define SSP_EXP_SEL1 4'h8
`define SSP_EXP_SEL2 4'h7
`define SSP_EXP_SEL3 4'h6
`define SSP_EXP_SEL4 4'h5
`define SSP_EXP_SEL5 4'h4
`define SSP_EXP_SEL6 4'h3

// Bits per frame
`define SSP_BITS 4'h8

// Reset values
`define SSP_TXF_RST 1'b1
`define SSP_DATA_RST 8'h00
`define SSP_LINE_IDLE 1'b1

`endif

/* common/ssp_pkg.sv */
package ssp_pkg;

    typedef enum logic [2:0] {
        SSP_ST_IDLE = 3'b001,
        SSP_ST_GAP = 3'b010,
        SSP_ST_SHIFT = 3'b100
    } ssp_state_t;

    typedef enum logic [1:0] {
        SSP_MODE_TX = 2'b00,
        SSP_MODE_RX = 2'b01,
        SSP_MODE_TRX = 2'b10,
        SSP_MODE_RSV = 2'b11
    } ssp_mode_t;

endpackage : ssp_pkg

/* hdl/ssp_presc.sv */
`timescale 1ns/1ps
`include "ssp_defs.svh"
module ssp_presc (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Control
    input wire logic run,
    input wire logic [2:0] sel,
    // Half period tick
    output logic tick
);
    import ssp_pkg::*;

    logic [11:0] cnt_q, cnt_d;
    logic tick_q, tick_d;
    logic [11:0] half_m1;

    function automatic logic [3:0] div_exp(input logic [2:0] s);
        logic [3:0] e;
        e = `SSP_EXP_SEL6;
        unique case (s)
            3'h0: e = `SSP_EXP_SEL0;
            3'h1: e = `SSP_EXP_SEL1;
            3'h2: e = `SSP_EXP_SEL2;
            3'h3: e = `SSP_EXP_SEL3;
            3'h4: e = `SSP_EXP_SEL4;
            3'h5: e = `SSP_EXP_SEL5;
            default: e = `SSP_EXP_SEL6;
        endcase
        return e;
    endfunction : div_exp

    always_comb begin
        half_m1 = (12'h001 << (div_exp(sel) - 4'h1)) - 12'h001;
        cnt_d = cnt_q + 12'h001;
        tick_d = 1'b0;
        // Restart from zero so every resumed clock gets a full half period
        if (!run) begin
            cnt_d = 12'h000;
        end else if (cnt_q >= half_m1) begin
            cnt_d = 12'h000;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_q <= 12'h000;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;

endmodule : ssp_presc

/* hdl/ssp_buf2.sv */
`timescale 1ns/1ps
module ssp_buf2 #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    import ssp_pkg::*;

    logic [W-1:0] d0_q, d0_d, d1_q, d1_d;
    logic v0_q, v0_d, v1_q, v1_d;
    logic push, pop;

    always_comb begin
        push = in_valid && !v1_q;
        pop = v0_q && out_ready;
        d0_d = d0_q;
        d1_d = d1_q;
        v0_d = v0_q;
        v1_d = v1_q;
        if (pop) begin
            if (v1_q) begin
                d0_d = d1_q;
                v1_d = push;
                if (push) begin
                    d1_d = in_data;
                end
            end else begin
                v0_d = push;
                if (push) begin
                    d0_d = in_data;
                end
            end
        end else if (push) begin
            if (!v0_q) begin
                d0_d = in_data;
                v0_d = 1'b1;
            end else begin
                d1_d = in_data;
                v1_d = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            d0_q <= '0;
            d1_q <= '0;
            v0_q <= 1'b0;
            v1_q <= 1'b0;
        end else begin
            d0_q <= d0_d;
            d1_q <= d1_d;
            v0_q <= v0_d;
            v1_q <= v1_d;
        end
    end

    // Ready is taken from the second slot so it never depends on out_ready
    assign in_ready = !v1_q;
    assign out_valid = v0_q;
    assign out_data = d0_q;

endmodule : ssp_buf2

/* test/ssp_peer.sv */
`timescale 1ns/1ps
// Far-side peer: clocks bytes in external mode, follows the device clock otherwise
module ssp_peer (
    // Clock
    input wire logic core_clk,
    // Device pins
    input wire logic sck_out,
    input wire logic sck_oe,
    input wire logic serial_out_pin,
    output logic sck_in,
    output logic serial_in_pin,
    // Shared setting
    input wire logic bit_order_bit
);
    logic ext_q = 1'b1;
    logic prev_q = 1'b1;
    logic [7:0] send_q = 8'h00;
    logic [7:0] got = 8'h00;
    logic [7:0] nb;
    logic [7:0] log_q[$];
    int bitn = 0;
    int cyc = 0;
    int t_last = 0;
    int t_prev = 0;
    initial serial_in_pin = 1'b0;
    // Pin level comes from whichever side has the clock enabled
    assign sck_in = sck_oe ? sck_out : ext_q;
    // Pulse width is the four core cycle minimum; clock idles high between bytes
    task automatic burst();
        repeat (8) begin
            ext_q <= 1'b0;
            repeat (4) @(posedge core_clk);
            ext_q <= 1'b1;
            repeat (4) @(posedge core_clk);
        end
    endtask : burst
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        prev_q <= sck_in;
        if (prev_q && !sck_in) begin
            serial_in_pin <= bit_order_bit ? send_q[bitn] : send_q[7 - bitn];
        end
        if (!prev_q && sck_in) begin
            nb = bit_order_bit ? {serial_out_pin, got[7:1]} : {got[6:0], serial_out_pin};
            got <= nb;
            bitn <= (bitn + 1) % 8;
            if (bitn == 7) begin
                log_q.push_back(nb);
                t_prev <= t_last;
                t_last <= cyc;
                send_q <= send_q + 8'h01;
                // Released line shows the opposite level, never a stale bit
                serial_in_pin <= ~serial_in_pin;
            end
        end
    end
endmodule : ssp_peer

/* test/sync_serial_tx_rx_control_tb.sv */
`timescale 1ns/1ps
module sync_serial_tx_rx_control_tb;
    import ssp_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic start_set = 1'b0;
    logic start_clr = 1'b0;
    logic force_stop = 1'b0;
    logic tx_wr = 1'b0;
    logic rx_ready = 1'b0;
    logic bit_order_bit = 1'b0;
    logic [7:0] tx_wdata = 8'h00;
    logic [2:0] clock_select_field = 3'h6;
    ssp_mode_t transfer_mode_field = SSP_MODE_TX;
    logic [7:0] rx_data;
    logic rx_valid, transfer_start_bit, tx_buffer_empty_flag, rx_buffer_full_flag;
    logic transfer_active_flag, shift_active_flag, tx_underrun_flag, rx_overrun_flag;
    logic serial_done_irq, sck_in, sck_out, sck_oe, serial_in_pin, serial_out_pin;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int irqs = 0;
    int n = 0;
    int t0 = 0;
    always #50 core_clk = ~core_clk;
    ssp_ctrl dut (.*);
    ssp_peer peer (.*);
    task automatic complete_run();
        if (errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    // One-cycle pulse, c = {start_set, start_clr, force_stop, tx_wr}
    task automatic cmd(input logic [3:0] c, input logic [7:0] d);
        {start_set, start_clr, force_stop, tx_wr} <= c;
        tx_wdata <= d;
        @(posedge core_clk);
        {start_set, start_clr, force_stop, tx_wr} <= 4'h0;
        @(posedge core_clk);
    endtask : cmd
    // Ready is held until the edge that takes the word
    task automatic get(input logic [7:0] exp);
        rx_ready <= 1'b1;
        for (int i = 0; i < 3000; i++) begin
            @(negedge core_clk);
            if (rx_valid === 1'b1) break;
        end
        check(rx_data, exp);
        @(posedge core_clk);
        rx_ready <= 1'b0;
        @(posedge core_clk);
    endtask : get
    task automatic wait_bytes(input int k);
        for (int i = 0; i < 3000 && peer.log_q.size() < k; i++) @(posedge core_clk);
        repeat (2) @(posedge core_clk);
    endtask : wait_bytes
    // Whole run needs under two thousand cycles; the ceiling leaves wide margin
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (serial_done_irq === 1'b1) irqs <= irqs + 1;
        if (cycles == 20000) begin
            errors++;
            complete_run();
        end
    end
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        check({tx_buffer_empty_flag, transfer_active_flag, rx_buffer_full_flag, tx_underrun_flag,
            rx_overrun_flag, serial_done_irq, serial_out_pin, sck_out}, 8'h83);
        // Internal clock transmit, continuous then auto-wait
        cmd(4'h1, 8'ha5);
        check(8'(tx_buffer_empty_flag), 8'h00);
        cmd(4'h8, 8'h00);
        for (n = 0; n < 200 && tx_buffer_empty_flag !== 1'b1; n++) @(posedge core_clk);
        cmd(4'h1, 8'h3c);
        wait_bytes(2);
        check(peer.log_q[0], 8'ha5);
        check(peer.log_q[1], 8'h3c);
        check(8'(peer.t_last - peer.t_prev), 8'h40);
        repeat (40) @(posedge core_clk);
        check(8'({sck_out, transfer_active_flag}), 8'h03);
        check(8'(peer.log_q.size()), 8'h02);
        t0 = peer.cyc;
        cmd(4'h1, 8'h81);
        for (n = 0; n < 20 && shift_active_flag !== 1'b1; n++) @(posedge core_clk);
        check(8'(shift_active_flag), 8'h01);
        cmd(4'h4, 8'h00);
        wait_bytes(3);
        check(peer.log_q[2], 8'h81);
        check(8'(peer.t_last - t0 < 80), 8'h01);
        repeat (20) @(posedge core_clk);
        check(8'({transfer_start_bit, transfer_active_flag, shift_active_flag, serial_out_pin, sck_out}),
            8'h03);
        // External clock transmit, underrun mid-run and on the first byte
        clock_select_field <= 3'h7;
        cmd(4'h1, 8'h5a);
        cmd(4'h8, 8'h00);
        peer.burst();
        repeat (2) @(posedge core_clk);
        check(peer.log_q[3], 8'h5a);
        check(8'(tx_underrun_flag), 8'h00);
        n = irqs;
        peer.burst();
        repeat (2) @(posedge core_clk);
        check(8'(tx_underrun_flag), 8'h01);
        check(peer.log_q[4], 8'hff);
        check(8'(irqs > n), 8'h01);
        cmd(4'h2, 8'h00);
        check(8'({transfer_start_bit, tx_buffer_empty_flag, transfer_active_flag, tx_underrun_flag}), 8'h04);
        n = irqs;
        cmd(4'h8, 8'h00);
        peer.burst();
        repeat (20) @(posedge core_clk);
        check(8'({tx_underrun_flag, irqs > n}), 8'h03);
        cmd(4'h2, 8'h00);
        // Internal clock receive, LSB first, consumer stalls until auto-wait
        transfer_mode_field <= SSP_MODE_RX;
        clock_select_field <= 3'h6;
        bit_order_bit <= 1'b1;
        peer.send_q = 8'hc3;
        t0 = peer.log_q.size();
        cmd(4'h8, 8'h00);
        for (n = 0; n < 12 && sck_out !== 1'b0; n++) @(posedge core_clk);
        check(8'({sck_oe, sck_out}), 8'h02);
        wait_bytes(t0 + 3);
        repeat (60) @(posedge core_clk);
        check(8'(peer.log_q.size() - t0), 8'h03);
        check(8'({rx_buffer_full_flag, sck_out}), 8'h03);
        get(8'hc3);
        get(8'hc4);
        get(8'hc5);
        get(8'hc6);
        cmd(4'h4, 8'h00);
        repeat (200) @(posedge core_clk);
        rx_ready <= 1'b1;
        repeat (10) @(posedge core_clk);
        rx_ready <= 1'b0;
        check(8'({transfer_active_flag, rx_buffer_full_flag}), 8'h00);
        // External clock receive with overrun
        clock_select_field <= 3'h7;
        bit_order_bit <= 1'b0;
        peer.send_q = 8'h11;
        n = irqs;
        cmd(4'h8, 8'h00);
        repeat (4) peer.burst();
        repeat (4) @(posedge core_clk);
        check(8'(irqs - n), 8'h04);
        check(8'({rx_overrun_flag, rx_buffer_full_flag}), 8'h03);
        peer.burst();
        repeat (4) @(posedge core_clk);
        check(8'(irqs - n), 8'h04);
        cmd(4'h4, 8'h00);
        get(8'h11);
        get(8'h12);
        get(8'h13);
        get(8'h14);
        repeat (4) @(posedge core_clk);
        check(8'({rx_overrun_flag, rx_buffer_full_flag}), 8'h00);
        cmd(4'h2, 8'h00);
        // Internal clock full duplex
        transfer_mode_field <= SSP_MODE_TRX;
        clock_select_field <= 3'h6;
        peer.send_q = 8'h69;
        t0 = peer.log_q.size();
        cmd(4'h1, 8'h96);
        cmd(4'h8, 8'h00);
        get(8'h69);
        wait_bytes(t0 + 1);
        check(peer.log_q[t0], 8'h96);
        check(8'(tx_buffer_empty_flag), 8'h01);
        cmd(4'h2, 8'h00);
        complete_run();
    end
endmodule : sync_serial_tx_rx_control_tb
